/* File: common/flash_ctrl_defines.svh */
// Offsets, field positions, reset values and map constants of the flash control block
`ifndef FLASH_CTRL_DEFINES_SVH
`define FLASH_CTRL_DEFINES_SVH

`define FOC_CTRL_OFS 8'h00
`define FOC_PROT_OFS 8'h04
`define FOC_ADDR_OFS 8'h08
`define FOC_DATA_OFS 8'h0C
`define FOC_STAT_OFS 8'h10

`define FOC_PGM_BIT 0
`define FOC_ERASE_BIT 1
`define FOC_WHOLE_BIT 2
`define FOC_HIGH_VOLTAGE_ENABLE_BIT 3

`define FOC_ST_CHECKED_BIT 0
`define FOC_ST_LATCHED_BIT 1
`define FOC_ST_BLOCKED_BIT 2
`define FOC_ST_ERASING_BIT 3
`define FOC_ST_SECURE_BIT 4

`define FOC_USER_BASE 16'hDC00
`define FOC_USER_LAST 16'hFBFF
`define FOC_VEC_BASE 16'hFFDC
`define FOC_USER_BYTES 16'h2000
`define FOC_VEC_BYTES 16'h0024
`define FOC_PAGE_LOG2 6
`define FOC_PROT_ALL_MAX 8'h70
`define FOC_PROT_RESET 8'hFF
`define FOC_ERASED_BYTE 8'hFF
`define FOC_RESP_OKAY 2'h0
`define FOC_RESP_SLVERR 2'h2

`endif

/* File: common/flash_ctrl_pkg.sv */
// Types shared by the flash control block
package flash_ctrl_pkg;
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SELECTED,
        SEQ_CHECKED,
        SEQ_LATCHED
    } seq_t;
endpackage

/* File: rtl/flash_operation_control.sv */
// Flash program and erase control with AXI4-Lite register access
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "flash_ctrl_defines.svh"

// Summary of operation
// R1 - Erased cells read one, programmed read zero
// R2 - Page erase clears one 64-byte page
// R3 - Array holds 8192 user plus 36 vector bytes
// R4 - User at DC00-FBFF, vectors at FFDC-FFFF
// R5 - Pump enable set only after proper sequence
// R6 - Pump runs exactly while enable is one
// R7 - Whole-array bit picks mass or page erase
// R8 - Program and erase never both set
// R9 - Program select configures program, reads back
// R10 - Erase select configures erase, reads back
// R11 - High voltage only from internal pump
// R12 - Security hides flash contents from reads
// R13 - Host reads protect boundary before enabling
// R14 - Protected target refuses pump enable
// R15 - Host keeps page erase timing
// R16 - Host programs rows byte by byte
// R17 - Refused enable still updates other bits
module flash_operation_control #(
    parameter int USER_BYTES = `FOC_USER_BYTES,
    parameter int VEC_BYTES = `FOC_VEC_BYTES,
    parameter int PAGE_LOG2 = `FOC_PAGE_LOG2
) (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic SECURE_LOCK,
    output logic PUMP_ON
);
    localparam int TOTAL = USER_BYTES + VEC_BYTES;
    localparam int IW = $clog2(TOTAL);

    if (USER_BYTES != 8192 || VEC_BYTES != 36 || PAGE_LOG2 != 6) begin : g_bad_params
        $error("flash_operation_control: unsupported array geometry");
    end

    logic pgm_ff, ers_ff, whole_ff, hv_ff;
    logic [7:0] bpr_ff;
    logic [15:0] tgt_ff;
    flash_ctrl_pkg::seq_t seq_ff;
    logic [7:0] mem [TOTAL];
    logic [IW-1:0] ecnt_ff;
    logic edone_ff;
    logic [2:0] sec_sync_ff;
    logic sec_ff;

    logic awready_ff, wready_ff, aw_have_ff, w_have_ff, bvalid_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff;
    logic arready_ff, rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    function automatic logic [IW:0] map_addr(input logic [15:0] a);
        logic [15:0] off;
        off = 16'h0000;
        map_addr = '0;
        if (a >= `FOC_USER_BASE && a <= `FOC_USER_LAST) begin // [R3] [R4]
            off = a - `FOC_USER_BASE;
            map_addr = {1'b1, off[IW-1:0]};
        end else if (a >= `FOC_VEC_BASE) begin // [R4]
            off = a - `FOC_VEC_BASE + `FOC_USER_BYTES;
            map_addr = {1'b1, off[IW-1:0]};
        end
    endfunction

    // Target decode and protection
    logic [IW:0] tgt_map;
    logic [IW-1:0] tgt_idx;
    logic [15:0] prot_start;
    logic tgt_prot, any_prot, vec_tgt, blocked;
    assign tgt_map = map_addr(tgt_ff);
    assign tgt_idx = tgt_map[IW-1:0];
    assign prot_start = {2'b11, bpr_ff, 6'h00};
    assign any_prot = bpr_ff != `FOC_PROT_RESET;
    assign tgt_prot = any_prot && (bpr_ff <= `FOC_PROT_ALL_MAX || tgt_ff >= prot_start); // [R14]
    assign vec_tgt = tgt_ff >= `FOC_VEC_BASE;
    // Vector page erases only as part of a mass erase
    assign blocked = (ers_ff && whole_ff) ? any_prot
                   : (tgt_prot || (ers_ff && vec_tgt) || !tgt_map[IW]); // [R14]

    // Bus handshakes
    logic aw_take, w_take, ar_take, do_wr;
    assign aw_take = AWVALID && awready_ff;
    assign w_take = WVALID && wready_ff;
    assign ar_take = ARVALID && arready_ff;
    assign do_wr = aw_have_ff && w_have_ff && !bvalid_ff;

    logic wr_ctrl, wr_prot, wr_addr, wr_data, wr_map, both_set, hv_ok;
    logic [3:0] wbits;
    assign wbits = wdata_ff[3:0];
    assign wr_ctrl = do_wr && awaddr_ff == `FOC_CTRL_OFS && wstrb_ff[0];
    assign wr_prot = do_wr && awaddr_ff == `FOC_PROT_OFS && wstrb_ff[0];
    assign wr_addr = do_wr && awaddr_ff == `FOC_ADDR_OFS;
    assign wr_data = do_wr && awaddr_ff == `FOC_DATA_OFS && wstrb_ff[0];
    assign wr_map = awaddr_ff == `FOC_CTRL_OFS || awaddr_ff == `FOC_PROT_OFS
                 || awaddr_ff == `FOC_ADDR_OFS || awaddr_ff == `FOC_DATA_OFS
                 || awaddr_ff == `FOC_STAT_OFS;
    assign both_set = wbits[`FOC_PGM_BIT] && wbits[`FOC_ERASE_BIT];
    // Enable only with unchanged selection after check and latch
    assign hv_ok = (wbits[`FOC_PGM_BIT] || wbits[`FOC_ERASE_BIT])
                && wbits[2:0] == {whole_ff, ers_ff, pgm_ff}
                && seq_ff == flash_ctrl_pkg::SEQ_LATCHED && !blocked; // [R5] [R14]

    logic erasing;
    logic [IW-1:0] ebase, elast, eidx;
    assign erasing = hv_ff && ers_ff && !edone_ff;
    assign ebase = whole_ff ? '0 : {tgt_idx[IW-1:PAGE_LOG2], {PAGE_LOG2{1'b0}}}; // [R2] [R7]
    assign elast = whole_ff ? IW'(TOTAL - 1) : IW'((1 << PAGE_LOG2) - 1);
    assign eidx = ebase + ecnt_ff;

    logic prog_ok;
    assign prog_ok = pgm_ff && hv_ff && tgt_map[IW] && !tgt_prot;

    // Security input synchroniser
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            sec_sync_ff <= 3'h0;
            sec_ff <= 1'b0;
        end else begin
            sec_sync_ff <= {sec_sync_ff[1:0], SECURE_LOCK};
            if (sec_sync_ff[1] == sec_sync_ff[2]) begin
                sec_ff <= sec_sync_ff[2];
            end
        end
    end

    // Write address and data capture
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (aw_take) begin
                awaddr_ff <= AWADDR;
                aw_have_ff <= 1'b1;
                awready_ff <= 1'b0;
            end
            if (w_take) begin
                wdata_ff <= WDATA;
                wstrb_ff <= WSTRB;
                w_have_ff <= 1'b1;
                wready_ff <= 1'b0;
            end
            if (bvalid_ff && BREADY) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // Write response
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `FOC_RESP_OKAY;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (!wr_map || (wr_ctrl && both_set)) ? `FOC_RESP_SLVERR
                      : `FOC_RESP_OKAY; // [R8]
        end else if (BREADY) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Control bits
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            pgm_ff <= 1'b0;
            ers_ff <= 1'b0;
            whole_ff <= 1'b0;
            hv_ff <= 1'b0;
        end else if (wr_ctrl && !both_set) begin // [R8]
            pgm_ff <= wbits[`FOC_PGM_BIT]; // [R9]
            ers_ff <= wbits[`FOC_ERASE_BIT]; // [R10]
            whole_ff <= wbits[`FOC_WHOLE_BIT]; // [R7]
            hv_ff <= wbits[`FOC_HIGH_VOLTAGE_ENABLE_BIT] && (hv_ff || hv_ok); // [R5] [R17] [R6] [R11]
        end
    end

    // Operation sequence tracking
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            seq_ff <= flash_ctrl_pkg::SEQ_IDLE;
        end else if (wr_ctrl && !both_set && wbits[2:0] != {whole_ff, ers_ff, pgm_ff}) begin
            seq_ff <= (wbits[`FOC_PGM_BIT] || wbits[`FOC_ERASE_BIT])
                    ? flash_ctrl_pkg::SEQ_SELECTED : flash_ctrl_pkg::SEQ_IDLE;
        end else if (ar_take && ARADDR == `FOC_PROT_OFS
                     && seq_ff == flash_ctrl_pkg::SEQ_SELECTED) begin // [R13]
            seq_ff <= flash_ctrl_pkg::SEQ_CHECKED;
        end else if (wr_addr && seq_ff == flash_ctrl_pkg::SEQ_CHECKED) begin
            seq_ff <= flash_ctrl_pkg::SEQ_LATCHED;
        end
    end

    // Protect boundary and target address
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            bpr_ff <= `FOC_PROT_RESET;
            tgt_ff <= `FOC_USER_BASE;
        end else begin
            if (wr_prot && bpr_ff == `FOC_PROT_RESET) begin // [R14]
                bpr_ff <= wdata_ff[7:0];
            end
            if (wr_addr && !hv_ff) begin
                if (wstrb_ff[0]) begin
                    tgt_ff[7:0] <= wdata_ff[7:0];
                end
                if (wstrb_ff[1]) begin
                    tgt_ff[15:8] <= wdata_ff[15:8];
                end
            end
        end
    end

    // Erase walker
    always_ff @(posedge MCLK) begin
        if (RESET || !hv_ff) begin
            ecnt_ff <= '0;
            edone_ff <= 1'b0;
        end else if (erasing) begin
            if (ecnt_ff == elast) begin
                edone_ff <= 1'b1;
            end else begin
                ecnt_ff <= ecnt_ff + 1'b1;
            end
        end
    end

    // Array storage
    always_ff @(posedge MCLK) begin
        if (erasing) begin
            mem[eidx] <= `FOC_ERASED_BYTE; // [R1] [R2] [R7]
        end else if (wr_data && prog_ok) begin
            mem[tgt_idx] <= mem[tgt_idx] & wdata_ff[7:0]; // [R1] [R16]
        end
    end

    // Read channel
    logic [IW:0] rd_map;
    logic [31:0] rd_val;
    logic rd_hit;
    assign rd_map = map_addr(tgt_ff);
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case (ARADDR)
            `FOC_CTRL_OFS: rd_val[3:0] = {hv_ff, whole_ff, ers_ff, pgm_ff}; // [R9] [R10]
            `FOC_PROT_OFS: rd_val[7:0] = bpr_ff;
            `FOC_ADDR_OFS: rd_val[15:0] = tgt_ff;
            `FOC_DATA_OFS: begin
                if (!sec_ff && rd_map[IW]) begin // [R12]
                    rd_val[7:0] = mem[rd_map[IW-1:0]];
                end
            end
            `FOC_STAT_OFS: begin
                rd_val[`FOC_ST_CHECKED_BIT] = seq_ff == flash_ctrl_pkg::SEQ_CHECKED;
                rd_val[`FOC_ST_LATCHED_BIT] = seq_ff == flash_ctrl_pkg::SEQ_LATCHED;
                rd_val[`FOC_ST_BLOCKED_BIT] = blocked;
                rd_val[`FOC_ST_ERASING_BIT] = erasing;
                rd_val[`FOC_ST_SECURE_BIT] = sec_ff;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `FOC_RESP_OKAY;
        end else if (ar_take) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_val;
            rresp_ff <= rd_hit ? `FOC_RESP_OKAY : `FOC_RESP_SLVERR;
        end else if (rvalid_ff && RREADY) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end

    assign AWREADY = awready_ff;
    assign WREADY = wready_ff;
    assign BVALID = bvalid_ff;
    assign BRESP = bresp_ff;
    assign ARREADY = arready_ff;
    assign RVALID = rvalid_ff;
    assign RDATA = rdata_ff;
    assign RRESP = rresp_ff;
    assign PUMP_ON = hv_ff; // [R6] [R11]

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    property p_never_both;
        !(pgm_ff && ers_ff);
    endproperty
    a_never_both: assert property (p_never_both) else $error("dual select held"); // [R8]

    property p_both_refused;
        wr_ctrl && both_set |=> $stable(pgm_ff) && $stable(ers_ff) && BRESP == `FOC_RESP_SLVERR;
    endproperty
    a_both_refused: assert property (p_both_refused) else $error("dual select kept"); // [R8]

    property p_pump_guard;
        $rose(PUMP_ON) |-> $past(seq_ff) == flash_ctrl_pkg::SEQ_LATCHED && !$past(blocked);
    endproperty
    a_pump_guard: assert property (p_pump_guard) else $error("pump out of sequence"); // [R5]

    property p_prot_block;
        wr_ctrl && blocked && !hv_ff |=> !PUMP_ON;
    endproperty
    a_prot_block: assert property (p_prot_block) else $error("protected pump enable"); // [R14]

    property p_refused_updates;
        wr_ctrl && !both_set && !hv_ok && !hv_ff
            |=> !PUMP_ON && pgm_ff == $past(wbits[0]) && ers_ff == $past(wbits[1]);
    endproperty
    a_refused_updates: assert property (p_refused_updates) else $error("ctrl bits lost"); // [R17]

    property p_ctrl_readback;
        ar_take && ARADDR == `FOC_CTRL_OFS
            |=> RVALID && RDATA[1:0] == {$past(ers_ff), $past(pgm_ff)};
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback) else $error("readback wrong"); // [R9]

    property p_erase_fill;
        erasing |=> mem[$past(eidx)] == `FOC_ERASED_BYTE;
    endproperty
    a_erase_fill: assert property (p_erase_fill) else $error("erased byte not all ones"); // [R1]

    property p_page_bound;
        erasing && !whole_ff |-> eidx[IW-1:PAGE_LOG2] == tgt_idx[IW-1:PAGE_LOG2];
    endproperty
    a_page_bound: assert property (p_page_bound) else $error("page erase left its page"); // [R2]

    property p_secure_read;
        ar_take && ARADDR == `FOC_DATA_OFS && sec_ff |=> RDATA == 32'h0000_0000;
    endproperty
    a_secure_read: assert property (p_secure_read) else $error("secure data leaked"); // [R12]
endmodule

/* File: sim/tb_flash_operation_control.sv */
// Register-level bench for the flash program and erase control block
`timescale 1ns/1ps
`include "flash_ctrl_defines.svh"
module tb_flash_operation_control;
    localparam logic [7:0] a_ctl = `FOC_CTRL_OFS;
    localparam logic [7:0] a_prt = `FOC_PROT_OFS;
    localparam logic [7:0] a_adr = `FOC_ADDR_OFS;
    localparam logic [7:0] a_dat = `FOC_DATA_OFS;
    localparam logic [7:0] a_sta = `FOC_STAT_OFS;
    localparam logic [1:0] ok = `FOC_RESP_OKAY;
    localparam logic [1:0] bad = `FOC_RESP_SLVERR;
    logic MCLK = 1'b0;
    logic RESET = 1'b1;
    logic AWVALID = 1'b0;
    logic WVALID = 1'b0;
    logic BREADY = 1'b0;
    logic ARVALID = 1'b0;
    logic RREADY = 1'b0;
    logic SECURE_LOCK = 1'b0;
    logic [7:0] AWADDR = 8'h00;
    logic [7:0] ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0000_0000;
    logic [3:0] WSTRB = 4'hF;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, PUMP_ON;
    logic [1:0] BRESP, RRESP, r;
    logic [31:0] RDATA, st;
    int err_count = 0;
    int n_checks = 0;

    always #12.5 MCLK = ~MCLK;

    flash_operation_control uut (.MCLK(MCLK), .RESET(RESET), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .SECURE_LOCK(SECURE_LOCK), .PUMP_ON(PUMP_ON));

    task automatic print_verdict();
        if (err_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic hang();
        err_count++;
        print_verdict();
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge MCLK);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge MCLK);
            n++;
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
        end while (BVALID !== 1'b1 && n < 50);
        if (BVALID !== 1'b1) hang();
        BREADY <= 1'b0;
        chk_resp(BRESP, er);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
        int n;
        n = 0;
        @(posedge MCLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge MCLK);
            n++;
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
        end while (RVALID !== 1'b1 && n < 50);
        if (RVALID !== 1'b1) hang();
        RREADY <= 1'b0;
        d = RDATA;
        rr = RRESP;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] rr;
        rd(a, d, rr);
        chk_resp(rr, ok);
        chk_val(d, exp);
    endtask

    task automatic pump(input logic exp);
        #1;
        chk_bit(PUMP_ON, exp);
    endtask

    task automatic arr(input logic [15:0] a, input logic [7:0] exp);
        wreg(a_adr, {16'h0000, a}, ok);
        rreg(a_dat, {24'h00_0000, exp});
    endtask

    // Select, read boundary, latch target, then ask for high voltage
    task automatic seq(input logic [31:0] c, input logic [15:0] a, input logic pe);
        wreg(a_ctl, c, ok);
        rd(a_prt, st, r);
        chk_resp(r, ok);
        wreg(a_adr, {16'h0000, a}, ok);
        wreg(a_ctl, c | 32'h0000_0008, ok);
        pump(pe);
        rreg(a_ctl, pe ? (c | 32'h0000_0008) : c);
    endtask

    // Selection dropped first, pump kept, then pump dropped
    task automatic hv_off();
        wreg(a_ctl, 32'h0000_0008, ok);
        pump(1'b1);
        wreg(a_ctl, 32'h0000_0000, ok);
        pump(1'b0);
    endtask

    task automatic drain();
        int n;
        rd(a_sta, st, r);
        chk_bit(st[`FOC_ST_ERASING_BIT], 1'b1);
        n = 0;
        while (st[`FOC_ST_ERASING_BIT] !== 1'b0 && n < 5000) begin
            rd(a_sta, st, r);
            n++;
        end
        if (st[`FOC_ST_ERASING_BIT] !== 1'b0) hang();
    endtask

    initial begin
        repeat (20) @(posedge MCLK);
        RESET <= 1'b0;
        rreg(a_ctl, 32'h0000_0000);
        rreg(a_prt, 32'h0000_00FF);
        pump(1'b0);
        wreg(8'h14, 32'h0000_0001, bad);
        wreg(a_ctl, 32'h0000_0003, bad);
        rreg(a_ctl, 32'h0000_0000);
        wreg(a_ctl, 32'h0000_0009, ok);
        pump(1'b0);
        rreg(a_ctl, 32'h0000_0001);
        // Boundary read skipped
        wreg(a_ctl, 32'h0000_0002, ok);
        wreg(a_adr, 32'h0000_DC00, ok);
        wreg(a_ctl, 32'h0000_000A, ok);
        pump(1'b0);
        rreg(a_ctl, 32'h0000_0002);
        wreg(a_ctl, 32'h0000_0000, ok);
        // Whole array erase
        seq(32'h0000_0006, 16'hDC00, 1'b1);
        drain();
        hv_off();
        arr(16'hDC00, 8'hFF);
        arr(16'hFBFF, 8'hFF);
        arr(16'hFFDC, 8'hFF);
        arr(16'hFFFF, 8'hFF);
        arr(16'hFC00, 8'h00);
        // Program last byte of one page and first of the next
        seq(32'h0000_0001, 16'hDC3F, 1'b1);
        wreg(a_dat, 32'h0000_00A5, ok);
        hv_off();
        arr(16'hDC3F, 8'hA5);
        seq(32'h0000_0001, 16'hDC40, 1'b1);
        wreg(a_dat, 32'h0000_003C, ok);
        hv_off();
        arr(16'hDC40, 8'h3C);
        // Page erase touches one page only
        seq(32'h0000_0002, 16'hDC3F, 1'b1);
        drain();
        hv_off();
        arr(16'hDC3F, 8'hFF);
        arr(16'hDC40, 8'h3C);
        seq(32'h0000_0002, 16'hFFE0, 1'b0);
        wreg(a_ctl, 32'h0000_0000, ok);
        // Hidden contents
        SECURE_LOCK <= 1'b1;
        repeat (6) @(posedge MCLK);
        arr(16'hDC40, 8'h00);
        rd(a_sta, st, r);
        chk_bit(st[`FOC_ST_SECURE_BIT], 1'b1);
        SECURE_LOCK <= 1'b0;
        repeat (6) @(posedge MCLK);
        arr(16'hDC40, 8'h3C);
        // Protected range from FBC0 upward
        wreg(a_prt, 32'h0000_00EF, ok);
        rreg(a_prt, 32'h0000_00EF);
        wreg(a_prt, 32'h0000_0055, ok);
        rreg(a_prt, 32'h0000_00EF);
        seq(32'h0000_0001, 16'hFBC0, 1'b0);
        wreg(a_ctl, 32'h0000_0000, ok);
        seq(32'h0000_0001, 16'hFBBF, 1'b1);
        hv_off();
        seq(32'h0000_0006, 16'hDC00, 1'b0);
        wreg(a_ctl, 32'h0000_0000, ok);
        print_verdict();
    end
endmodule
